// ---- rtl/vtc_top.sv ----
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "vtc_cfg.svh"
// Summary of operation
// - Normal, repeat and block transfer modes, chosen per descriptor.
// - Each activation reads descriptor unless read-skip applies, moves data, then writes descriptor back.
// - Count covers 1 to 65536 in normal and block, 1 to 256 in repeat.
// - Descriptor picks byte, word or longword element size.
// - CPU interrupt after every transfer or only after the last one.
// - Chaining lets one request process several descriptors in sequence.
// - Descriptor start address low two bits forced to zero on fetch.
// - Fetch takes four longword reads, or three in short-address operation.
// - Software sets vector base; vector address is base plus source offset.
// - Read start address from vector entry, then fetch descriptor there.
// - Pin requests 0-7 use vectors 64-71, enabled by first register bits 15-8.
// - Serial 1 receive-full uses vector 245, fifth register bit 13.
// - Serial 1 transmit-empty uses vector 246, fifth register bit 12.
// - Each serial request moves one data element, or one whole block in block mode.
// - Four bus release timings and two priority orderings are selectable.
// - Descriptor read-skip option and a module stop setting.
// - Enable bit routes a source to the controller instead of the CPU.
// - Mode field value zero selects normal transfer.
// - Source address control value two increments source after each transfer.
module vtc_top import vtc_pkg::*; (
   input wire logic CLK, // Bus clock
   input wire logic SYS_RST, // Async reset
   input wire vtc_apb_req_s APB_I, // APB request
   output vtc_apb_rsp_s APB_O, // APB answer
   output vtc_mem_req_s MEM_O, // Memory request
   input wire vtc_mem_rsp_s MEM_I, // Memory answer
   input wire logic [9:0] REQ, // 0-7 pins, 8 rx full, 9 tx empty
   output logic [9:0] SRC_ACK, // Element moved, clears request
   output logic [9:0] CPU_INT // Interrupt to CPU per source
);
   vtc_state_s s_q, s_d;
   logic [9:0] en_vec, pend;
   logic [3:0] sel;
   logic [2:0] nwords;
   logic [31:0] esz, back, rd;
   logic sh, bus_ack, last_w, apb_wr, apb_hit;

   function automatic logic [7:0] vec_num(input logic [3:0] i);
      case (i)
         4'h8: vec_num = `VTC_VEC_RX;
         4'h9: vec_num = `VTC_VEC_TX;
         default: vec_num = `VTC_VEC_EXT0 + {5'h0, i[2:0]};
      endcase
   endfunction : vec_num

   function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] c, input logic [31:0] n);
      case (c)
         `VTC_ADDR_INC: step = a + n;
         `VTC_ADDR_DEC: step = a - n;
         default: step = a;
      endcase
   endfunction : step

   function automatic logic [31:0] sext24(input logic [23:0] v);
      sext24 = {{8{v[23]}}, v};
   endfunction : sext24

   function automatic logic [31:0] desc_word(input vtc_state_s s, input logic [2:0] i, input logic short_m);
      if (short_m) begin
         case (i)
            3'h0: desc_word = {s.mode_a, s.src_addr[23:0]};
            3'h1: desc_word = {s.mode_b, s.dst_addr[23:0]};
            default: desc_word = {s.cnt_a, s.cnt_b};
         endcase
      end else begin
         case (i)
            3'h0: desc_word = {s.mode_a, s.mode_b, 16'h0000};
            3'h1: desc_word = s.src_addr;
            3'h2: desc_word = s.dst_addr;
            default: desc_word = {s.cnt_a, s.cnt_b};
         endcase
      end
   endfunction : desc_word

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         en_vec[i] = s_q.ena[7-i];
      end
      en_vec[8] = s_q.ene[1];
      en_vec[9] = s_q.ene[0];
      pend = REQ & en_vec;
      sel = 4'h0;
      for (int i = 9; i >= 0; i--) begin
         if (pend[i]) begin
            sel = 4'(i);
         end
      end
      if (s_q.ctrl[`VTC_CTRL_PRIO] && (pend[8] || pend[9])) begin
         sel = pend[8] ? 4'h8 : 4'h9;
      end
      sh = s_q.ctrl[`VTC_CTRL_SHORT];
      nwords = sh ? `VTC_DESC_SHORT : `VTC_DESC_LONG;
      // Reserved size code treated as longword
      esz = (s_q.mode_a[`VTC_A_SIZE] > `VTC_SIZE_LONG) ? 32'h4 : 32'h1 << s_q.mode_a[`VTC_A_SIZE];
      back = 32'({s_q.cnt_a[15:8] == 8'h00, s_q.cnt_a[15:8]}) << s_q.mode_a[`VTC_A_SIZE];
      last_w = s_q.widx == nwords - 3'h1;
      rd = MEM_I.rdata;
   end

   // Bus request only while no release gap remains
   always_comb begin
      MEM_O.req = (s_q.st != ST_IDLE) && (s_q.gap == 2'h0);
      MEM_O.we = (s_q.st == ST_XWR) || (s_q.st == ST_WB);
      MEM_O.size = (s_q.st == ST_XRD || s_q.st == ST_XWR) ? s_q.mode_a[`VTC_A_SIZE] : `VTC_SIZE_LONG;
      MEM_O.wdata = (s_q.st == ST_WB) ? desc_word(s_q, s_q.widx, sh) : s_q.data;
      case (s_q.st)
         ST_VEC: MEM_O.addr = s_q.vbr + `VTC_VEC_OFS + {22'h0, vec_num(s_q.src), 2'h0};
         ST_DESC, ST_WB: MEM_O.addr = s_q.dstart + {27'h0, s_q.widx, 2'h0};
         ST_XRD: MEM_O.addr = s_q.src_addr;
         ST_XWR: MEM_O.addr = s_q.dst_addr;
         default: MEM_O.addr = 32'h0;
      endcase
      bus_ack = MEM_O.req && MEM_I.ack;
   end

   always_comb begin
      apb_wr = APB_I.psel && APB_I.penable && APB_I.pwrite;
      apb_hit = 1'b1;
      case (APB_I.paddr)
         `VTC_OFS_CTRL: APB_O.prdata = {26'h0, s_q.ctrl};
         `VTC_OFS_VBR: APB_O.prdata = s_q.vbr;
         `VTC_OFS_ENA: APB_O.prdata = {16'h0, s_q.ena, 8'h00};
         `VTC_OFS_ENE: APB_O.prdata = {18'h0, s_q.ene, 12'h000};
         `VTC_OFS_STAT: APB_O.prdata = {24'h0, s_q.last_src, s_q.st != ST_IDLE, s_q.st};
         default: begin
            APB_O.prdata = 32'h0;
            apb_hit = 1'b0;
         end
      endcase
      APB_O.pready = 1'b1;
      APB_O.pslverr = APB_I.psel && APB_I.penable && !apb_hit;
   end

   always_comb begin
      s_d = s_q;
      s_d.ack = 10'h000;
      s_d.cpu_int = REQ & ~en_vec;
      if (apb_wr) begin
         case (APB_I.paddr)
            `VTC_OFS_CTRL: s_d.ctrl = APB_I.pwdata[5:0];
            `VTC_OFS_VBR: begin
               s_d.vbr = APB_I.pwdata;
               s_d.skip_ok = 1'b0;
            end
            `VTC_OFS_ENA: s_d.ena = APB_I.pwdata[`VTC_ENA_EXT];
            `VTC_OFS_ENE: s_d.ene = {APB_I.pwdata[`VTC_ENE_RX], APB_I.pwdata[`VTC_ENE_TX]};
            default: ;
         endcase
      end
      if (s_q.gap != 2'h0) begin
         s_d.gap = s_q.gap - 2'h1;
      end
      if (bus_ack) begin
         s_d.gap = s_q.ctrl[`VTC_CTRL_REL];
      end
      case (s_q.st)
         ST_IDLE: begin
            if (!s_q.ctrl[`VTC_CTRL_STOP] && pend != 10'h000) begin
               s_d.src = sel;
               s_d.gap = 2'h0;
               s_d.widx = 3'h0;
               if (s_q.ctrl[`VTC_CTRL_SKIP] && s_q.skip_ok && sel == s_q.last_src) begin
                  s_d.st = ST_XRD;
                  s_d.blk = (s_q.mode_a[`VTC_A_MODE] == `VTC_MODE_BLOCK) ? s_q.cnt_a[15:8] : 8'h01;
               end else begin
                  s_d.st = ST_VEC;
               end
            end
         end
         ST_VEC: begin
            if (bus_ack) begin
               s_d.dstart = {rd[31:2], 2'h0};
               s_d.st = ST_DESC;
            end
         end
         ST_DESC: begin
            if (bus_ack) begin
               s_d.widx = s_q.widx + 3'h1;
               case ({sh, s_q.widx})
                  4'h0: {s_d.mode_a, s_d.mode_b} = rd[31:16];
                  4'h1: s_d.src_addr = rd;
                  4'h2: s_d.dst_addr = rd;
                  4'h8: begin
                     s_d.mode_a = rd[31:24];
                     s_d.src_addr = sext24(rd[23:0]);
                  end
                  4'h9: begin
                     s_d.mode_b = rd[31:24];
                     s_d.dst_addr = sext24(rd[23:0]);
                  end
                  default: {s_d.cnt_a, s_d.cnt_b} = rd;
               endcase
               if (last_w) begin
                  s_d.st = ST_XRD;
                  s_d.blk = (s_q.mode_a[`VTC_A_MODE] == `VTC_MODE_BLOCK) ? rd[31:24] : 8'h01;
               end
            end
         end
         ST_XRD: begin
            if (bus_ack) begin
               s_d.data = rd;
               s_d.st = ST_XWR;
            end
         end
         ST_XWR: begin
            if (bus_ack) begin
               s_d.ack[s_q.src] = 1'b1;
               s_d.src_addr = step(s_q.src_addr, s_q.mode_a[`VTC_A_SRC], esz);
               s_d.dst_addr = step(s_q.dst_addr, s_q.mode_b[`VTC_B_DST], esz);
               if (s_q.blk != 8'h01) begin
                  s_d.blk = s_q.blk - 8'h01;
                  s_d.st = ST_XRD;
               end else begin
                  s_d.fin = 1'b0;
                  s_d.st = ST_WB;
                  s_d.widx = 3'h0;
                  case (s_q.mode_a[`VTC_A_MODE])
                     `VTC_MODE_NORMAL: begin
                        s_d.cnt_a = s_q.cnt_a - 16'h0001;
                        s_d.fin = s_q.cnt_a == 16'h0001;
                     end
                     `VTC_MODE_REPEAT: begin
                        s_d.cnt_a[7:0] = (s_q.cnt_a[7:0] == 8'h01) ? s_q.cnt_a[15:8] : s_q.cnt_a[7:0] - 8'h01;
                     end
                     default: begin
                        s_d.cnt_b = s_q.cnt_b - 16'h0001;
                        s_d.fin = s_q.cnt_b == 16'h0001;
                     end
                  endcase
                  // Repeat wraps and block ends return the area pointer to its start
                  if ((s_q.mode_a[`VTC_A_MODE] == `VTC_MODE_REPEAT && s_q.cnt_a[7:0] == 8'h01)
                      || s_q.mode_a[`VTC_A_MODE] == `VTC_MODE_BLOCK) begin
                     if (s_q.mode_b[`VTC_B_RPTDST]) begin
                        s_d.dst_addr = step(s_d.dst_addr, ~s_q.mode_b[`VTC_B_DST] | 2'h2, back);
                     end else begin
                        s_d.src_addr = step(s_d.src_addr, ~s_q.mode_a[`VTC_A_SRC] | 2'h2, back);
                     end
                     if (s_q.mode_a[`VTC_A_MODE] == `VTC_MODE_REPEAT && s_q.mode_b[`VTC_B_RPTDST]
                         && s_q.mode_b[`VTC_B_DST] < `VTC_ADDR_INC) begin
                        s_d.dst_addr = s_q.dst_addr;
                     end
                  end
               end
            end
         end
         ST_WB: begin
            if (bus_ack) begin
               s_d.widx = s_q.widx + 3'h1;
               if (last_w) begin
                  s_d.last_src = s_q.src;
                  s_d.skip_ok = !s_q.mode_b[`VTC_B_CHAIN];
                  if (s_q.mode_b[`VTC_B_EVERY] || s_q.fin) begin
                     s_d.cpu_int[s_q.src] = 1'b1;
                  end
                  if (s_q.mode_b[`VTC_B_CHAIN] && (!s_q.mode_b[`VTC_B_CHAINZ] || s_q.fin)) begin
                     s_d.dstart = s_q.dstart + {27'h0, nwords, 2'h0};
                     s_d.widx = 3'h0;
                     s_d.st = ST_DESC;
                  end else begin
                     s_d.st = ST_IDLE;
                  end
               end
            end
         end
         default: s_d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign SRC_ACK = s_q.ack;
   assign CPU_INT = s_q.cpu_int;

   // Descriptor read counter watched by the fetch-length check
   logic [2:0] rdcnt_q;
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rdcnt_q <= 3'h0;
      end else begin
         rdcnt_q <= (s_q.st != ST_DESC) ? 3'h0 : rdcnt_q + {2'h0, bus_ack};
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   AST_ALIGN: assert property ((s_q.st == ST_DESC) |-> s_q.dstart[1:0] == 2'h0)
      else $error("Descriptor start not word aligned");
   AST_FETCH: assert property ((s_q.st == ST_DESC && s_d.st == ST_XRD) |-> rdcnt_q == nwords - 3'h1)
      else $error("Wrong descriptor read count");
   AST_VEC: assert property ((s_q.st == ST_VEC && MEM_O.req) |-> MEM_O.addr[11:2] == {2'h1, vec_num(s_q.src)}
      && MEM_O.addr[31:12] == s_q.vbr[31:12] + {19'h0, s_q.vbr[11:10] == 2'h3})
      else $error("Vector address mismatch");
   AST_SRCINC: assert property ((s_q.st == ST_XWR && bus_ack && s_q.mode_a[`VTC_A_SRC] == `VTC_ADDR_INC
      && s_q.mode_a[`VTC_A_MODE] == `VTC_MODE_NORMAL) |=> s_q.src_addr == $past(s_q.src_addr) + $past(esz))
      else $error("Source address not incremented");
   AST_ONEACK: assert property ((SRC_ACK != 10'h000) |-> $onehot(SRC_ACK) && $past(s_q.st) == ST_XWR)
      else $error("Element acknowledge without write");
   AST_IRQ: assert property ((s_q.st == ST_WB && bus_ack && last_w && (s_q.fin || s_q.mode_b[`VTC_B_EVERY]))
      |=> CPU_INT[$past(s_q.src)])
      else $error("Missing completion interrupt");
   AST_STOP: assert property ((s_q.st == ST_IDLE && s_q.ctrl[`VTC_CTRL_STOP]) |=> s_q.st == ST_IDLE)
      else $error("Activation while stopped");
   AST_ENA: assert property ((s_q.st == ST_IDLE && s_d.st != ST_IDLE) |-> en_vec[sel] && REQ[sel])
      else $error("Activation from disabled source");
   AST_ORDER: assert property ($rose(s_q.st == ST_WB) |-> $past(s_q.st) == ST_XWR ##1 s_q.st != ST_XRD)
      else $error("Write-back out of order");
   AST_CNT: assert property ((s_q.st == ST_XWR && bus_ack && s_q.blk == 8'h01
      && s_q.mode_a[`VTC_A_MODE] == `VTC_MODE_NORMAL) |=> s_q.cnt_a == $past(s_q.cnt_a) - 16'h0001)
      else $error("Normal count not decremented");

   COV_CHAIN: cover property (s_q.st == ST_WB && s_d.st == ST_DESC);
   COV_SKIP: cover property (s_q.st == ST_IDLE && s_d.st == ST_XRD);
   COV_BLOCK: cover property (s_q.st == ST_XWR && s_d.st == ST_XRD);
   COV_SHORT: cover property (s_q.st == ST_DESC && s_d.st == ST_XRD && sh);
endmodule : vtc_top

// ---- rtl/vtc_cfg.svh ----
`ifndef VTC_CFG_SVH
`define VTC_CFG_SVH
// Register byte offsets on the bus
`define VTC_OFS_CTRL 8'h00
`define VTC_OFS_VBR 8'h04
`define VTC_OFS_ENA 8'h08
`define VTC_OFS_ENE 8'h0c
`define VTC_OFS_STAT 8'h10
// Control register fields
`define VTC_CTRL_SKIP 0
`define VTC_CTRL_STOP 1
`define VTC_CTRL_SHORT 2
`define VTC_CTRL_REL 4:3
`define VTC_CTRL_PRIO 5
`define VTC_CTRL_RST 6'h00
// Source enable fields
`define VTC_ENA_EXT 15:8
`define VTC_ENE_RX 13
`define VTC_ENE_TX 12
// Vector numbers and table offset
`define VTC_VEC_EXT0 8'h40
`define VTC_VEC_RX 8'hf5
`define VTC_VEC_TX 8'hf6
`define VTC_VEC_OFS 32'h0000_0400
// Descriptor length in longwords
`define VTC_DESC_LONG 3'h4
`define VTC_DESC_SHORT 3'h3
// Mode byte A fields and codes
`define VTC_A_MODE 7:6
`define VTC_A_SIZE 5:4
`define VTC_A_SRC 3:2
`define VTC_MODE_NORMAL 2'h0
`define VTC_MODE_REPEAT 2'h1
`define VTC_MODE_BLOCK 2'h2
`define VTC_ADDR_INC 2'h2
`define VTC_ADDR_DEC 2'h3
`define VTC_SIZE_LONG 2'h2
// Mode byte B fields
`define VTC_B_CHAIN 7
`define VTC_B_CHAINZ 6
`define VTC_B_EVERY 5
`define VTC_B_RPTDST 4
`define VTC_B_DST 3:2
`endif

// ---- rtl/vtc_pkg.sv ----
package vtc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_VEC = 3'h1,
      ST_DESC = 3'h2,
      ST_XRD = 3'h3,
      ST_XWR = 3'h4,
      ST_WB = 3'h5
   } vtc_st_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } vtc_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } vtc_apb_rsp_s;

   typedef struct packed {
      logic req;
      logic we;
      logic [1:0] size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } vtc_mem_req_s;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
   } vtc_mem_rsp_s;

   typedef struct packed {
      vtc_st_e st;
      logic [2:0] widx;
      logic [1:0] gap;
      logic [3:0] src;
      logic [3:0] last_src;
      logic skip_ok;
      logic fin;
      logic [31:0] dstart;
      logic [7:0] mode_a;
      logic [7:0] mode_b;
      logic [31:0] src_addr;
      logic [31:0] dst_addr;
      logic [15:0] cnt_a;
      logic [15:0] cnt_b;
      logic [7:0] blk;
      logic [31:0] data;
      logic [5:0] ctrl;
      logic [31:0] vbr;
      logic [7:0] ena;
      logic [1:0] ene;
      logic [9:0] ack;
      logic [9:0] cpu_int;
   } vtc_state_s;
endpackage : vtc_pkg

// ---- dv/vtc_mem_model.sv ----
`timescale 1ns/10ps
module vtc_mem_model import vtc_pkg::*; (
   input wire logic clk, // Bus clock
   input wire logic rst, // Reset
   input wire logic slow, // Two wait cycles
   input wire vtc_mem_req_s mreq, // Request
   output vtc_mem_rsp_s mrsp // Answer
);
   logic [7:0] mem [logic [31:0]];
   logic [31:0] addr_log [$];
   logic we_log [$];
   int wait_n;
   function automatic logic [7:0] rb(input logic [31:0] a);
      return mem.exists(a) ? mem[a] : 8'h00;
   endfunction : rb
   function automatic void pb(input logic [31:0] a, input logic [7:0] d);
      mem[a] = d;
   endfunction : pb
   function automatic logic [31:0] get32(input logic [31:0] a);
      return {rb(a), rb(a + 32'h1), rb(a + 32'h2), rb(a + 32'h3)};
   endfunction : get32
   function automatic void put32(input logic [31:0] a, input logic [31:0] d);
      for (int i = 0; i < 4; i++) mem[a + 32'(i)] = d[31 - 8 * i -: 8];
   endfunction : put32
   function automatic void clear_log();
      addr_log.delete();
      we_log.delete();
   endfunction : clear_log
   // Big-endian store, element data in the low bits of the bus
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mrsp <= '0;
         wait_n <= 0;
      end else begin
         mrsp.ack <= 1'b0;
         // Stale read data must never look valid
         mrsp.rdata <= ~mrsp.rdata;
         if (mreq.req && !mrsp.ack) begin
            if (slow && wait_n < 2) begin
               wait_n <= wait_n + 1;
            end else begin
               wait_n <= 0;
               mrsp.ack <= 1'b1;
               addr_log.push_back(mreq.addr);
               we_log.push_back(mreq.we);
               if (mreq.we) begin
                  if (mreq.size == 2'h0) pb(mreq.addr, mreq.wdata[7:0]);
                  else if (mreq.size == 2'h1) begin
                     pb(mreq.addr, mreq.wdata[15:8]);
                     pb(mreq.addr + 32'h1, mreq.wdata[7:0]);
                  end else put32(mreq.addr, mreq.wdata);
               end else if (mreq.size == 2'h0) mrsp.rdata <= {24'h0, rb(mreq.addr)};
               else if (mreq.size == 2'h1) mrsp.rdata <= {16'h0, rb(mreq.addr), rb(mreq.addr + 32'h1)};
               else mrsp.rdata <= get32(mreq.addr);
            end
         end
      end
   end
endmodule : vtc_mem_model

// ---- dv/vectored_transfer_controller_test.sv ----
`timescale 1ns/10ps
`include "vtc_cfg.svh"
module vectored_transfer_controller_test import vtc_pkg::*;;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic slow = 1'b0;
   logic [9:0] req = '0;
   logic [9:0] src_ack;
   logic [9:0] cpu_int;
   vtc_apb_req_s apb_i = '0;
   vtc_apb_rsp_s apb_o;
   vtc_mem_req_s mem_o;
   vtc_mem_rsp_s mem_i;
   int num_errors = 0;
   int cmp_count = 0;
   logic [31:0] vbr = 32'h0001_0000;
   always #20 clk = ~clk;
   vtc_top dut_u (.CLK(clk), .SYS_RST(sys_rst), .APB_I(apb_i), .APB_O(apb_o), .MEM_O(mem_o), .MEM_I(mem_i),
      .REQ(req), .SRC_ACK(src_ack), .CPU_INT(cpu_int));
   vtc_mem_model mem_u (.clk(clk), .rst(sys_rst), .slow(slow), .mreq(mem_o), .mrsp(mem_i));
   task automatic stop_test;
      if (num_errors == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      @(posedge clk);
      apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
      @(posedge clk);
      apb_i.penable <= 1'b1;
      n = 0;
      // Look at the settled answer mid-cycle, the transfer ends at the next rising edge
      do begin
         @(negedge clk);
         n++;
      end while (apb_o.pready !== 1'b1 && n < 50);
      rd = apb_o.prdata;
      err = apb_o.pslverr;
      @(posedge clk);
      apb_i <= '0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] d;
      logic e;
      apb(1'b1, a, wd, d, e);
   endtask : wr
   task automatic put_desc(input logic [31:0] ds, input logic sh, input logic [7:0] ma, input logic [7:0] mb,
                           input logic [31:0] sa, input logic [31:0] da, input logic [15:0] cnt);
      if (sh) begin
         mem_u.put32(ds, {ma, sa[23:0]});
         mem_u.put32(ds + 32'h4, {mb, da[23:0]});
         mem_u.put32(ds + 32'h8, {cnt, 16'h0});
      end else begin
         mem_u.put32(ds, {ma, mb, 16'h0});
         mem_u.put32(ds + 32'h4, sa);
         mem_u.put32(ds + 32'h8, da);
         mem_u.put32(ds + 32'hc, {cnt, 16'h0});
      end
   endtask : put_desc
   // One activation: vector, descriptor, one element, write-back
   task automatic act(input int s, input logic [31:0] va, input int dl, input logic [31:0] ds,
                      input logic [31:0] sa, input logic [31:0] da, input logic ei);
      int n;
      logic gi;
      mem_u.clear_log();
      slow <= 1'($urandom_range(1));
      req[s] <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (src_ack[s] !== 1'b1 && n < 500);
      @(posedge clk);
      req[s] <= 1'b0;
      n = 0;
      gi = 1'b0;
      while (mem_u.addr_log.size() < 2 * dl + 3 && n < 500) begin
         @(negedge clk);
         n++;
      end
      repeat (4) begin
         @(negedge clk);
         gi = gi | cpu_int[s];
      end
      chk(32'(mem_u.addr_log.size()), 32'(2 * dl + 3), "count");
      chk(mem_u.addr_log[0], va, "vector");
      for (int k = 1; k <= dl; k++) chk(mem_u.addr_log[k], ds + 32'(4 * (k - 1)), "desc");
      chk(mem_u.addr_log[dl + 1], sa, "src");
      chk(mem_u.addr_log[dl + 2], da, "dst");
      for (int k = 0; k < 2 * dl + 3; k++) chk(32'(mem_u.we_log[k]), 32'(k >= dl + 2), "dir");
      chk(32'(gi), 32'(ei), "irq");
   endtask : act
   initial begin
      logic [31:0] d;
      logic e;
      logic [7:0] b;
      int n;
      void'($urandom(32'haba86670));
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0, d, e);
         chk(d, 32'h0, "reset");
         chk(32'(e), 32'(i == 5), "unmapped");
      end
      wr(`VTC_OFS_VBR, vbr);
      wr(`VTC_OFS_ENE, 32'h0000_1000);
      // Low bits set on purpose, the fetch must ignore them
      mem_u.put32(vbr + 32'h7d8, 32'h0000_2003);
      n = $urandom_range(4, 1);
      put_desc(32'h2000, 1'b0, 8'h08, 8'h00, 32'h3000, 32'h8800, 16'(n));
      for (int k = 0; k < 4; k++) mem_u.pb(32'h3000 + 32'(k), 8'($urandom));
      for (int k = 0; k < n; k++) begin
         act(9, vbr + 32'h7d8, 4, 32'h2000, 32'h3000 + 32'(k), 32'h8800, k == n - 1);
         chk(32'(mem_u.rb(32'h8800)), 32'(mem_u.rb(32'h3000 + 32'(k))), "tx");
      end
      chk(mem_u.get32(32'h2004), 32'h3000 + 32'(n), "wb src");
      chk(mem_u.get32(32'h200c), 32'h0, "wb cnt");
      // Short form only with on-chip addresses
      wr(`VTC_OFS_CTRL, 32'h0000_0004);
      wr(`VTC_OFS_ENE, 32'h0000_2000);
      mem_u.put32(vbr + 32'h7d4, 32'h0000_2040);
      n = $urandom_range(3, 1);
      put_desc(32'h2040, 1'b1, 8'h00, 8'h08, 32'hffff_8804, 32'h4000, 16'(n));
      for (int k = 0; k < n; k++) begin
         b = 8'($urandom);
         mem_u.pb(32'hffff_8804, b);
         act(8, vbr + 32'h7d4, 3, 32'h2040, 32'hffff_8804, 32'h4000 + 32'(k), k == n - 1);
         chk(32'(mem_u.rb(32'h4000 + 32'(k))), 32'(b), "rx");
      end
      wr(`VTC_OFS_CTRL, 32'h0);
      wr(`VTC_OFS_ENE, 32'h0);
      for (int i = 0; i < 8; i++) begin
         wr(`VTC_OFS_ENA, 32'h8000 >> i);
         mem_u.put32(vbr + 32'h500 + 32'(4 * i), 32'h0000_2100);
         put_desc(32'h2100, 1'b0, 8'h08, 8'h20, 32'h3100, 32'h3200, 16'h1);
         act(i, vbr + 32'h500 + 32'(4 * i), 4, 32'h2100, 32'h3100, 32'h3200, 1'b1);
      end
      // Block of two bytes, source area rewinds, widest release gap
      wr(`VTC_OFS_CTRL, 32'h0000_0018);
      wr(`VTC_OFS_ENA, 32'h0000_4000);
      mem_u.put32(vbr + 32'h504, 32'h0000_2200);
      put_desc(32'h2200, 1'b0, 8'h88, 8'h08, 32'h3300, 32'h3400, 16'h0200);
      mem_u.put32(32'h220c, 32'h0200_0001);
      mem_u.put32(32'h3300, $urandom);
      mem_u.clear_log();
      req[1] <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (src_ack[1] !== 1'b1 && n < 500);
      @(posedge clk);
      req[1] <= 1'b0;
      n = 0;
      while (mem_u.addr_log.size() < 13 && n < 500) begin
         @(negedge clk);
         n++;
      end
      repeat (8) @(posedge clk);
      chk(32'(mem_u.addr_log.size()), 32'd13, "blk count");
      chk(mem_u.get32(32'h3400) >> 16, mem_u.get32(32'h3300) >> 16, "blk data");
      chk(mem_u.get32(32'h2204), 32'h3300, "blk rewind");
      chk(mem_u.get32(32'h2208), 32'h3402, "blk dst");
      chk(mem_u.get32(32'h220c), 32'h0200_0000, "blk cnt");
      wr(`VTC_OFS_ENA, 32'h0);
      mem_u.clear_log();
      req[0] <= 1'b1;
      repeat (3) @(posedge clk);
      chk(32'(cpu_int[0]), 32'h1, "pass");
      req[0] <= 1'b0;
      wr(`VTC_OFS_CTRL, 32'h0000_0002);
      wr(`VTC_OFS_ENA, 32'h0000_8000);
      req[0] <= 1'b1;
      repeat (10) @(posedge clk);
      chk(32'(mem_u.addr_log.size()), 32'h0, "stop");
      req[0] <= 1'b0;
      wr(`VTC_OFS_CTRL, 32'h0);
      put_desc(32'h2100, 1'b0, 8'h08, 8'h20, 32'h3100, 32'h3200, 16'h1);
      act(0, vbr + 32'h500, 4, 32'h2100, 32'h3100, 32'h3200, 1'b1);
      stop_test();
   end
   // Run needs well under a thousand cycles per activation
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      stop_test();
   end
endmodule : vectored_transfer_controller_test
